// ==== pkg/bsg_consts.svh ====
// Constants of the blit surface geometry and format stage.
// Assumes inclusion by bare name from the design files.
`ifndef BSG_CONSTS_SVH
`define BSG_CONSTS_SVH
`define BSG_A_SRC_SIZE   8'h00
`define BSG_A_DST_SIZE   8'h04
`define BSG_A_DST_XY     8'h08
`define BSG_A_SRC_XY     8'h0c
`define BSG_A_SRC_FMT    8'h10
`define BSG_A_DST_FMT    8'h14
`define BSG_A_CMD        8'h18
`define BSG_M_SIZE       32'h1fff1fff
`define BSG_M_XY         32'h1fff1fff
`define BSG_M_SRC_FMT    32'h00ff3fff
`define BSG_M_DST_FMT    32'h00073fff
`define BSG_M_CMD        32'h0000c10f
`define BSG_RST_REG      32'h00000000
`define BSG_XL 0
`define BSG_XH 12
`define BSG_YL 16
`define BSG_YH 28
`define BSG_STRH 13
`define BSG_TSTRH 6
`define BSG_FMTL 16
`define BSG_SFMTH 19
`define BSG_DFMTH 18
`define BSG_BSWZ 20
`define BSG_WSWZ 21
`define BSG_PKL 22
`define BSG_PKH 23
`define BSG_INIT 8
`define BSG_XDIR 14
`define BSG_YDIR 15
// Command codes (low nibble of the command register)
`define BSG_OP_BLT    4'h1
`define BSG_OP_STR    4'h2
`define BSG_OP_HOST   4'h3
`define BSG_OP_LINE   4'h6
`define BSG_OP_PLINE  4'h7
`define BSG_OP_POLY   4'h8
`define BSG_YUV_OFS   9'h080
`define BSG_K_RV      18'sh00167
`define BSG_K_GU      18'sh00058
`define BSG_K_GV      18'sh000b7
`define BSG_K_BU      18'sh001c6
`endif

// ==== pkg/bsg_pkg.sv ====
// Types of the blit surface geometry and format stage.
// Assumes nothing beyond a SystemVerilog compiler.
package bsg_pkg;
   typedef enum logic [3:0] {
      BSG_S_MONO = 4'h0, BSG_S_8 = 4'h1, BSG_S_16 = 4'h3, BSG_S_24 = 4'h4,
      BSG_S_32 = 4'h5, BSG_S_YUYV = 4'h8, BSG_S_UYVY = 4'h9
   } bsg_sfmt_t;
   typedef enum logic [2:0] {
      BSG_D_8 = 3'h1, BSG_D_16 = 3'h3, BSG_D_24 = 3'h4, BSG_D_32 = 3'h5
   } bsg_dfmt_t;
   typedef enum logic [1:0] {
      BSG_P_STRIDE = 2'h0, BSG_P_BYTE = 2'h1, BSG_P_WORD = 2'h2
   } bsg_pack_t;
endpackage

// ==== hw/bsg_top.sv ====
// Surface geometry, host-port swizzle and colour conversion for a blitter.
// Assumes one 25 MHz clock, a simple strobe register port, datapath pulses.
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "bsg_consts.svh"
module bsg_top #(
   parameter int AW = 8
) (
   input  wire logic          MCLK,
   input  wire logic          RST,
   input  wire logic [AW-1:0] ADDR,
   input  wire logic [31:0]   WDATA,
   input  wire logic          WR,
   input  wire logic          RD,
   output logic      [31:0]   RDATA,
   input  wire logic          SRC_TILED,
   input  wire logic          DST_TILED,
   input  wire logic          SPAN_NEXT,
   input  wire logic          POLY_L_VLD,
   input  wire logic          POLY_R_VLD,
   input  wire logic [31:0]   POLY_XY,
   input  wire logic          HOST_VLD,
   input  wire logic [31:0]   HOST_DIN,
   output logic               HOST_DOUT_VLD,
   output logic      [31:0]   HOST_DOUT,
   input  wire logic          PIX_VLD,
   input  wire logic [31:0]   PIX_IN,
   input  wire logic [4:0]    PIX_IDX,
   input  wire logic [31:0]   COLOR_FG,
   input  wire logic [31:0]   COLOR_BG,
   output logic               PIX_OUT_VLD,
   output logic      [31:0]   PIX_OUT,
   output logic               PIX_BAD,
   output logic               LAUNCH,
   output logic      [12:0]   BLT_SRC_W,
   output logic      [12:0]   BLT_SRC_H,
   output logic      [12:0]   BLT_DST_W,
   output logic      [12:0]   BLT_DST_H,
   output logic               X_DIR,
   output logic               Y_DIR,
   output logic      [12:0]   SEG_X0,
   output logic      [12:0]   SEG_Y0,
   output logic      [12:0]   SEG_X1,
   output logic      [12:0]   SEG_Y1,
   output logic      [17:0]   SRC_STRIDE,
   output logic      [13:0]   DST_STRIDE,
   output logic      [4:0]    ALIGN
);
   logic [31:0] src_size, dst_size, dst_xy, src_xy, src_fmt, dst_fmt, cmd;
   logic [3:0]  op;
   logic        poly, mono, cmd_wr, init_wr;
   logic [5:0]  bpp;
   logic [18:0] row_bits;
   logic [17:0] next_stride;
   assign op      = cmd[3:0];
   assign poly    = (op == `BSG_OP_POLY);
   assign mono    = (src_fmt[`BSG_SFMTH:`BSG_FMTL] == bsg_pkg::BSG_S_MONO);
   assign cmd_wr  = WR && (ADDR == `BSG_A_CMD);
   assign init_wr = cmd_wr && WDATA[`BSG_INIT];

   // Register writes; hardware vertex updates win over a same-cycle write
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         src_size <= `BSG_RST_REG;
         dst_size <= `BSG_RST_REG;
         src_fmt  <= `BSG_RST_REG;
         dst_fmt  <= `BSG_RST_REG;
         cmd      <= `BSG_RST_REG;
      end else if (WR) begin
         unique case (ADDR)
            `BSG_A_SRC_SIZE: src_size <= WDATA & `BSG_M_SIZE;
            `BSG_A_DST_SIZE: dst_size <= WDATA & `BSG_M_SIZE;
            `BSG_A_SRC_FMT:  src_fmt  <= WDATA & `BSG_M_SRC_FMT;
            `BSG_A_DST_FMT:  dst_fmt  <= WDATA & `BSG_M_DST_FMT;
            `BSG_A_CMD:      cmd      <= WDATA & `BSG_M_CMD;
            default: ;
         endcase
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         src_xy <= `BSG_RST_REG;
      end else if (poly && POLY_L_VLD) begin
         src_xy <= POLY_XY & `BSG_M_XY;
      end else if (WR && ADDR == `BSG_A_SRC_XY) begin
         src_xy <= WDATA & `BSG_M_XY;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         dst_xy <= `BSG_RST_REG;
      end else if (init_wr && WDATA[3:0] == `BSG_OP_POLY) begin
         dst_xy <= src_xy;
      end else if (poly && POLY_R_VLD) begin
         dst_xy <= POLY_XY & `BSG_M_XY;
      end else if (WR && ADDR == `BSG_A_DST_XY) begin
         dst_xy <= WDATA & `BSG_M_XY;
      end
   end

   // Read port, one cycle latency, unmapped reads zero
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         RDATA <= `BSG_RST_REG;
      end else if (RD) begin
         unique case (ADDR)
            `BSG_A_SRC_SIZE: RDATA <= src_size;
            `BSG_A_DST_SIZE: RDATA <= dst_size;
            `BSG_A_DST_XY:   RDATA <= dst_xy;
            `BSG_A_SRC_XY:   RDATA <= src_xy;
            `BSG_A_SRC_FMT:  RDATA <= src_fmt;
            `BSG_A_DST_FMT:  RDATA <= dst_fmt;
            `BSG_A_CMD:      RDATA <= cmd;
            default:         RDATA <= `BSG_RST_REG;
         endcase
      end else begin
         RDATA <= `BSG_RST_REG;
      end
   end

   // Geometry outputs
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         LAUNCH    <= 1'b0;
         BLT_SRC_W <= 13'h0000;
         BLT_SRC_H <= 13'h0000;
         BLT_DST_W <= 13'h0000;
         BLT_DST_H <= 13'h0000;
         X_DIR     <= 1'b0;
         Y_DIR     <= 1'b0;
      end else begin
         LAUNCH    <= init_wr;
         BLT_DST_W <= dst_size[`BSG_XH:`BSG_XL];
         BLT_DST_H <= dst_size[`BSG_YH:`BSG_YL];
         if (op == `BSG_OP_STR) begin
            BLT_SRC_W <= src_size[`BSG_XH:`BSG_XL];
            BLT_SRC_H <= src_size[`BSG_YH:`BSG_YL];
         end else begin
            BLT_SRC_W <= dst_size[`BSG_XH:`BSG_XL];
            BLT_SRC_H <= dst_size[`BSG_YH:`BSG_YL];
         end
         X_DIR <= (op == `BSG_OP_BLT) && cmd[`BSG_XDIR];
         Y_DIR <= (op == `BSG_OP_BLT || op == `BSG_OP_HOST) && cmd[`BSG_YDIR];
      end
   end

   // Segment end points for lines and polylines
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         SEG_X0 <= 13'h0000;
         SEG_Y0 <= 13'h0000;
         SEG_X1 <= 13'h0000;
         SEG_Y1 <= 13'h0000;
      end else if (op == `BSG_OP_LINE || op == `BSG_OP_PLINE) begin
         SEG_X0 <= src_xy[`BSG_XH:`BSG_XL];
         SEG_Y0 <= src_xy[`BSG_YH:`BSG_YL];
         SEG_X1 <= dst_xy[`BSG_XH:`BSG_XL];
         SEG_Y1 <= dst_xy[`BSG_YH:`BSG_YL];
      end
   end

   // Source bits per pixel
   always_comb begin
      unique case (src_fmt[`BSG_SFMTH:`BSG_FMTL])
         bsg_pkg::BSG_S_MONO: bpp = 6'h01;
         bsg_pkg::BSG_S_8:    bpp = 6'h08;
         bsg_pkg::BSG_S_16, bsg_pkg::BSG_S_YUYV, bsg_pkg::BSG_S_UYVY: bpp = 6'h10;
         bsg_pkg::BSG_S_24:   bpp = 6'h18;
         bsg_pkg::BSG_S_32:   bpp = 6'h20;
         default:             bpp = 6'h00;
      endcase
   end

   assign row_bits = 19'(BLT_SRC_W) * 19'(bpp);
   always_comb begin
      unique case (src_fmt[`BSG_PKH:`BSG_PKL])
         bsg_pkg::BSG_P_BYTE: next_stride = 18'((row_bits + 19'h00007) >> 3);
         bsg_pkg::BSG_P_WORD: next_stride = 18'(((row_bits + 19'h0000f) >> 4) << 1);
         default: next_stride = SRC_TILED ? {11'h000, src_fmt[`BSG_TSTRH:0]}
                                          : {4'h0, src_fmt[`BSG_STRH:0]};
      endcase
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         SRC_STRIDE <= 18'h00000;
         DST_STRIDE <= 14'h0000;
      end else begin
         SRC_STRIDE <= next_stride;
         DST_STRIDE <= DST_TILED ? {7'h00, dst_fmt[`BSG_TSTRH:0]}
                                 : dst_fmt[`BSG_STRH:0];
      end
   end

   // Host blit first pixel alignment, advanced per span
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         ALIGN <= 5'h00;
      end else if (init_wr && WDATA[3:0] == `BSG_OP_HOST) begin
         ALIGN <= mono ? src_xy[4:0] : {3'h0, src_xy[1:0]};
      end else if (SPAN_NEXT && op == `BSG_OP_HOST) begin
         if (mono) begin
            ALIGN <= 5'(ALIGN + {SRC_STRIDE[1:0], 3'h0});
         end else begin
            ALIGN <= {3'h0, 2'(ALIGN[1:0] + SRC_STRIDE[1:0])};
         end
      end
   end

   // Host port swizzle
   logic [31:0] bswz, wswz;
   assign bswz = src_fmt[`BSG_BSWZ] ? {HOST_DIN[7:0], HOST_DIN[15:8],
                                       HOST_DIN[23:16], HOST_DIN[31:24]} : HOST_DIN;
   assign wswz = src_fmt[`BSG_WSWZ] ? {bswz[15:0], bswz[31:16]} : bswz;
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         HOST_DOUT_VLD <= 1'b0;
         HOST_DOUT     <= 32'h00000000;
      end else begin
         HOST_DOUT_VLD <= HOST_VLD;
         if (HOST_VLD) begin
            HOST_DOUT <= wswz;
         end
      end
   end

   // Colour conversion
   function automatic logic [7:0] clamp8(input logic signed [17:0] v);
      clamp8 = (v < 0) ? 8'h00 : (v > 18'sh000ff) ? 8'hff : v[7:0];
   endfunction

   logic [7:0]  cy, cu, cv, r8, g8, b8, a8;
   logic signed [17:0] su, sv;
   logic [31:0] next_pix;
   logic        next_bad, is_rgb;
   always_comb begin
      cy = PIX_IDX[0] ? PIX_IN[23:16] : PIX_IN[7:0];
      cu = PIX_IN[15:8];
      cv = PIX_IN[31:24];
      if (src_fmt[`BSG_SFMTH:`BSG_FMTL] == bsg_pkg::BSG_S_UYVY) begin
         cy = PIX_IDX[0] ? PIX_IN[31:24] : PIX_IN[15:8];
         cu = PIX_IN[7:0];
         cv = PIX_IN[23:16];
      end
      su = 18'(signed'({1'b0, cu}) - signed'(`BSG_YUV_OFS));
      sv = 18'(signed'({1'b0, cv}) - signed'(`BSG_YUV_OFS));
      is_rgb = 1'b1;
      a8 = 8'h00;
      r8 = PIX_IN[23:16];
      g8 = PIX_IN[15:8];
      b8 = PIX_IN[7:0];
      next_bad = 1'b0;
      next_pix = 32'h00000000;
      unique case (src_fmt[`BSG_SFMTH:`BSG_FMTL])
         bsg_pkg::BSG_S_16: begin
            r8 = {PIX_IN[15:11], PIX_IN[15:13]};
            g8 = {PIX_IN[10:5], PIX_IN[10:9]};
            b8 = {PIX_IN[4:0], PIX_IN[4:2]};
         end
         bsg_pkg::BSG_S_YUYV, bsg_pkg::BSG_S_UYVY: begin
            r8 = clamp8(18'($signed({10'h000, cy}) + ((`BSG_K_RV * sv) >>> 8)));
            g8 = clamp8(18'($signed({10'h000, cy}) - ((`BSG_K_GU * su + `BSG_K_GV * sv) >>> 8)));
            b8 = clamp8(18'($signed({10'h000, cy}) + ((`BSG_K_BU * su) >>> 8)));
         end
         bsg_pkg::BSG_S_24: ;
         bsg_pkg::BSG_S_32: a8 = (dst_fmt[`BSG_DFMTH:`BSG_FMTL] == bsg_pkg::BSG_D_32) ?
                                 PIX_IN[31:24] : 8'h00;
         default: is_rgb = 1'b0;
      endcase
      unique case (dst_fmt[`BSG_DFMTH:`BSG_FMTL])
         bsg_pkg::BSG_D_8: begin
            if (src_fmt[`BSG_SFMTH:`BSG_FMTL] == bsg_pkg::BSG_S_8) begin
               next_pix = {24'h000000, PIX_IN[7:0]};
            end else if (!mono) begin
               next_bad = 1'b1;
            end
         end
         bsg_pkg::BSG_D_16: begin
            if (src_fmt[`BSG_SFMTH:`BSG_FMTL] == bsg_pkg::BSG_S_16) begin
               next_pix = {16'h0000, PIX_IN[15:0]};
            end else begin
               next_pix = {16'h0000, r8[7:3], g8[7:2], b8[7:3]};
            end
            next_bad = !is_rgb && !mono;
         end
         bsg_pkg::BSG_D_24, bsg_pkg::BSG_D_32: begin
            next_pix = {a8, r8, g8, b8};
            next_bad = !is_rgb && !mono;
         end
         default: next_bad = 1'b1;
      endcase
      if (mono) begin
         next_pix = PIX_IN[{PIX_IDX[4:3], ~PIX_IDX[2:0]}] ? COLOR_FG : COLOR_BG;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         PIX_OUT_VLD <= 1'b0;
         PIX_OUT     <= 32'h00000000;
         PIX_BAD     <= 1'b0;
      end else begin
         PIX_OUT_VLD <= PIX_VLD;
         if (PIX_VLD) begin
            PIX_OUT <= next_bad ? 32'h00000000 : next_pix;
            PIX_BAD <= next_bad;
         end
      end
   end

   // Checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   property p_src_size;
      (op == `BSG_OP_STR) |=> (BLT_SRC_W == $past(src_size[`BSG_XH:`BSG_XL]));
   endproperty
   a_src_size: assert property (p_src_size) else $error("stretch width not used");
   property p_same_size;
      (op != `BSG_OP_STR) |=> (BLT_SRC_H == BLT_DST_H) && (BLT_SRC_W == BLT_DST_W);
   endproperty
   a_same_size: assert property (p_same_size) else $error("source size not destination");
   property p_host_ltr;
      (op == `BSG_OP_HOST) |=> !X_DIR;
   endproperty
   a_host_ltr: assert property (p_host_ltr) else $error("host blit right to left");
   sequence s_poly_init;
      init_wr && WDATA[3:0] == `BSG_OP_POLY;
   endsequence
   property p_poly_copy;
      s_poly_init |=> (dst_xy == $past(src_xy));
   endproperty
   a_poly_copy: assert property (p_poly_copy) else $error("vertex copy missed");
   property p_poly_left;
      (poly && POLY_L_VLD) ##1 (!POLY_L_VLD && !WR)
         ##1 (poly && RD && ADDR == `BSG_A_SRC_XY && !POLY_L_VLD && !WR)
         |=> (RDATA == ($past(POLY_XY, 3) & `BSG_M_XY));
   endproperty
   a_poly_left: assert property (p_poly_left) else $error("left vertex not read");
   sequence s_host_init;
      init_wr && WDATA[3:0] == `BSG_OP_HOST && mono;
   endsequence
   property p_align;
      s_host_init |=> (ALIGN == $past(src_xy[4:0]));
   endproperty
   a_align: assert property (p_align) else $error("alignment not loaded");
   property p_span;
      (SPAN_NEXT && op == `BSG_OP_HOST && !mono && !init_wr)
         |=> (ALIGN[1:0] == 2'($past(ALIGN[1:0]) + $past(SRC_STRIDE[1:0])));
   endproperty
   a_span: assert property (p_span) else $error("span alignment wrong");
   property p_swz;
      HOST_VLD && src_fmt[`BSG_BSWZ] && src_fmt[`BSG_WSWZ]
         |=> (HOST_DOUT == {$past(HOST_DIN[23:16]), $past(HOST_DIN[31:24]),
                            $past(HOST_DIN[7:0]), $past(HOST_DIN[15:8])});
   endproperty
   a_swz: assert property (p_swz) else $error("swizzle order wrong");
   property p_pack;
      (src_fmt[`BSG_PKH:`BSG_PKL] == bsg_pkg::BSG_P_WORD) |=> !SRC_STRIDE[0];
   endproperty
   a_pack: assert property (p_pack) else $error("word packed stride odd");
   property p_rsvd;
      (RD && ADDR == `BSG_A_SRC_FMT) |=> (RDATA[31:24] == 8'h00) && (RDATA[15:14] == 2'h0);
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
   property p_alpha;
      PIX_VLD && !mono && src_fmt[`BSG_SFMTH:`BSG_FMTL] != bsg_pkg::BSG_S_32
         && dst_fmt[`BSG_DFMTH:`BSG_FMTL] == bsg_pkg::BSG_D_32 |=> (PIX_OUT[31:24] == 8'h00);
   endproperty
   a_alpha: assert property (p_alpha) else $error("alpha byte not zero");

endmodule // bsg_top

// ==== bench/bsg_host_model.sv ====
// Host model: register port master and host-port data source.
// Assumes one clock; every signal changes by non-blocking assignment after a rising edge.
`timescale 1ns/1ps
`include "bsg_consts.svh"
module bsg_host_model (
   input  wire logic        mclk,
   output logic      [7:0]  addr,
   output logic      [31:0] wdata,
   output logic             wr,
   output logic             rd,
   input  wire logic [31:0] rdata,
   output logic             host_vld,
   output logic      [31:0] host_din,
   input  wire logic        host_dout_vld,
   input  wire logic [31:0] host_dout
);
   initial begin
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      host_vld = 1'b0;
      host_din = 32'h0;
   end
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr    <= 1'b0;
      wdata <= ~d;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // Source format writes keep to the software limits
   task automatic src_fmt(input logic [3:0] f, input logic [1:0] pk, input logic [1:0] swz,
                          input logic [13:0] st, input logic tiled);
      logic [13:0] s;
      logic [1:0]  p;
      s = f[3] ? {st[13:2], 2'b00} : st;
      p = tiled ? 2'h0 : pk;
      reg_wr(`BSG_A_SRC_FMT, {8'h00, p, swz, f, 2'b00, s});
   endtask
   // Blit source coordinates are never negative
   task automatic src_xy(input logic [12:0] x, input logic [12:0] y);
      reg_wr(`BSG_A_SRC_XY, {3'h0, y[12] ? 13'h0 : y, 3'h0, x[12] ? 13'h0 : x});
   endtask
   task automatic host_push(input logic [31:0] d, output logic v, output logic [31:0] q);
      @(posedge mclk);
      host_vld <= 1'b1;
      host_din <= d;
      @(posedge mclk);
      host_vld <= 1'b0;
      host_din <= ~d;
      #1 v = host_dout_vld;
      q = host_dout;
   endtask
endmodule // bsg_host_model

// ==== bench/bsg_top_tb_top.sv ====
// Testbench: register, geometry, stride, swizzle and pixel conversion tests.
// Assumes the host model drives the register port and host port.
`timescale 1ns/1ps
`include "bsg_consts.svh"
module bsg_top_tb_top;
   logic        MCLK = 1'b0;
   logic        RST = 1'b1;
   logic [7:0]  ADDR;
   logic        WR, RD, HOST_VLD, HOST_DOUT_VLD, PIX_OUT_VLD, PIX_BAD, LAUNCH, X_DIR, Y_DIR;
   logic [31:0] WDATA, RDATA, HOST_DIN, HOST_DOUT, PIX_OUT;
   logic        SRC_TILED = 1'b0, DST_TILED = 1'b0, SPAN_NEXT = 1'b0;
   logic        POLY_L_VLD = 1'b0, POLY_R_VLD = 1'b0, PIX_VLD = 1'b0;
   logic [31:0] POLY_XY = 32'h0, PIX_IN = 32'h0;
   logic [31:0] COLOR_FG = 32'h00a1b2c3, COLOR_BG = 32'h00102030;
   logic [4:0]  PIX_IDX = 5'h0, ALIGN;
   logic [12:0] BLT_SRC_W, BLT_SRC_H, BLT_DST_W, BLT_DST_H, SEG_X0, SEG_Y0, SEG_X1, SEG_Y1;
   logic [17:0] SRC_STRIDE;
   logic [13:0] DST_STRIDE;
   int          fail_count = 0, samples_checked = 0, cycles = 0;
   always #20 MCLK = ~MCLK;
   bsg_top #(.AW(8)) i_dut (.MCLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .SRC_TILED,
      .DST_TILED, .SPAN_NEXT, .POLY_L_VLD, .POLY_R_VLD, .POLY_XY, .HOST_VLD, .HOST_DIN,
      .HOST_DOUT_VLD, .HOST_DOUT, .PIX_VLD, .PIX_IN, .PIX_IDX, .COLOR_FG, .COLOR_BG,
      .PIX_OUT_VLD, .PIX_OUT, .PIX_BAD, .LAUNCH, .BLT_SRC_W, .BLT_SRC_H, .BLT_DST_W,
      .BLT_DST_H, .X_DIR, .Y_DIR, .SEG_X0, .SEG_Y0, .SEG_X1, .SEG_Y1, .SRC_STRIDE,
      .DST_STRIDE, .ALIGN);
   bsg_host_model i_host (.mclk(MCLK), .addr(ADDR), .wdata(WDATA), .wr(WR), .rd(RD),
      .rdata(RDATA), .host_vld(HOST_VLD), .host_din(HOST_DIN),
      .host_dout_vld(HOST_DOUT_VLD), .host_dout(HOST_DOUT));
   task automatic close_out;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge MCLK) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         close_out();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic settle;
      repeat (3) @(posedge MCLK);
      #1;
   endtask
   task automatic poly(input logic l, input logic [31:0] xy);
      @(posedge MCLK);
      POLY_XY <= xy;
      POLY_L_VLD <= l;
      POLY_R_VLD <= !l;
      @(posedge MCLK);
      POLY_L_VLD <= 1'b0;
      POLY_R_VLD <= 1'b0;
      POLY_XY <= ~xy;
   endtask
   task automatic span;
      @(posedge MCLK);
      SPAN_NEXT <= 1'b1;
      @(posedge MCLK);
      SPAN_NEXT <= 1'b0;
      settle();
   endtask
   task automatic strd(input logic [3:0] f, input logic [1:0] pk, input logic t,
                       input logic [31:0] e);
      @(posedge MCLK);
      SRC_TILED <= t;
      i_host.src_fmt(f, pk, 2'h0, 14'h2abc, t);
      settle();
      chk("src_stride", e, 32'(SRC_STRIDE));
   endtask
   task automatic conv(input logic [3:0] s, input logic [2:0] d, input logic [31:0] in,
                       input logic [4:0] idx, input logic [31:0] e, input logic bad);
      i_host.src_fmt(s, 2'h0, 2'h0, 14'h0, 1'b0);
      i_host.reg_wr(`BSG_A_DST_FMT, {13'h0, d, 16'h0});
      @(posedge MCLK);
      PIX_VLD <= 1'b1;
      PIX_IN <= in;
      PIX_IDX <= idx;
      @(posedge MCLK);
      PIX_VLD <= 1'b0;
      PIX_IN <= ~in;
      #1 chk("pix_vld", 32'h1, 32'(PIX_OUT_VLD));
      chk("pix_out", e, PIX_OUT);
      chk("pix_bad", 32'(bad), 32'(PIX_BAD));
   endtask
   initial begin
      logic [7:0]  ra [7];
      logic [31:0] rm [7];
      logic [31:0] sw [4];
      logic [31:0] d;
      logic        v;
      ra = '{`BSG_A_SRC_SIZE, `BSG_A_DST_SIZE, `BSG_A_DST_XY, `BSG_A_SRC_XY,
             `BSG_A_SRC_FMT, `BSG_A_DST_FMT, 8'h1c};
      rm = '{`BSG_M_SIZE, `BSG_M_SIZE, `BSG_M_XY, `BSG_M_XY, `BSG_M_SRC_FMT,
             `BSG_M_DST_FMT, 32'h0};
      sw = '{32'h11223344, 32'h44332211, 32'h33441122, 32'h22114433};
      repeat (2) @(posedge MCLK);
      RST <= 1'b0;
      for (int k = 0; k < 7; k++) begin
         i_host.reg_rd(ra[k], d);
         chk("reg_reset", 32'h0, d);
         i_host.reg_wr(ra[k], 32'hffffffff);
         i_host.reg_rd(ra[k], d);
         chk("reg_mask", rm[k], d);
      end
      $display("test registers done");
      i_host.reg_wr(`BSG_A_SRC_SIZE, 32'h00050009);
      i_host.reg_wr(`BSG_A_DST_SIZE, 32'h00030007);
      for (int k = 0; k < 4; k++) begin
         i_host.reg_wr(`BSG_A_CMD, {16'h0, 2'(k), 14'h1});
         settle();
         chk("x_dir", 32'(k & 1), 32'(X_DIR));
         chk("y_dir", 32'(k >> 1), 32'(Y_DIR));
         chk("src_w", 32'd7, 32'(BLT_SRC_W));
         chk("src_h", 32'd3, 32'(BLT_SRC_H));
      end
      i_host.reg_wr(`BSG_A_CMD, 32'h0000c002);
      settle();
      chk("src_w", 32'd9, 32'(BLT_SRC_W));
      chk("src_h", 32'd5, 32'(BLT_SRC_H));
      chk("dst_w", 32'd7, 32'(BLT_DST_W));
      chk("dst_h", 32'd3, 32'(BLT_DST_H));
      i_host.reg_wr(`BSG_A_CMD, 32'h0000c003);
      settle();
      chk("x_dir", 32'h0, 32'(X_DIR));
      chk("y_dir", 32'h1, 32'(Y_DIR));
      $display("test sizes done");
      i_host.src_xy(13'h12, 13'h34);
      i_host.reg_wr(`BSG_A_DST_XY, 32'h00560078);
      i_host.reg_wr(`BSG_A_CMD, 32'h00000006);
      settle();
      chk("seg", 32'h00340012, {3'h0, SEG_Y0, 3'h0, SEG_X0});
      chk("seg", 32'h00560078, {3'h0, SEG_Y1, 3'h0, SEG_X1});
      i_host.reg_wr(`BSG_A_CMD, 32'h00000007);
      i_host.reg_wr(`BSG_A_DST_XY, 32'h00660088);
      settle();
      chk("seg_x1", 32'h88, 32'(SEG_X1));
      $display("test lines done");
      i_host.reg_wr(`BSG_A_CMD, 32'h00000008);
      poly(1'b1, 32'h00200010);
      i_host.reg_rd(`BSG_A_SRC_XY, d);
      chk("src_xy", 32'h00200010, d);
      poly(1'b0, 32'h00300040);
      i_host.reg_rd(`BSG_A_DST_XY, d);
      chk("dst_xy", 32'h00300040, d);
      i_host.reg_wr(`BSG_A_CMD, 32'h00000108);
      #1 chk("launch", 32'h1, 32'(LAUNCH));
      settle();
      chk("launch", 32'h0, 32'(LAUNCH));
      i_host.reg_rd(`BSG_A_DST_XY, d);
      chk("dst_xy", 32'h00200010, d);
      chk("seg_x1", 32'h88, 32'(SEG_X1));
      $display("test polygon done");
      i_host.src_fmt(4'h0, 2'h0, 2'h0, 14'h3, 1'b0);
      i_host.src_xy(13'h5, 13'h0);
      i_host.reg_wr(`BSG_A_CMD, 32'h00000103);
      settle();
      chk("align", 32'd5, 32'(ALIGN));
      span();
      chk("align", 32'd29, 32'(ALIGN));
      span();
      chk("align", 32'd21, 32'(ALIGN));
      i_host.src_fmt(4'h3, 2'h0, 2'h0, 14'h3, 1'b0);
      i_host.src_xy(13'h6, 13'h0);
      i_host.reg_wr(`BSG_A_CMD, 32'h00000103);
      settle();
      chk("align", 32'd2, 32'(ALIGN));
      span();
      chk("align", 32'd1, 32'(ALIGN));
      $display("test alignment done");
      strd(4'h4, 2'h0, 1'b0, 32'h2abc);
      strd(4'h4, 2'h1, 1'b1, 32'h3c);
      strd(4'h4, 2'h1, 1'b0, 32'd21);
      strd(4'h4, 2'h2, 1'b0, 32'd22);
      strd(4'h0, 2'h1, 1'b0, 32'd1);
      strd(4'h0, 2'h2, 1'b0, 32'd2);
      i_host.reg_wr(`BSG_A_DST_FMT, 32'h00031234);
      settle();
      chk("dst_stride", 32'h1234, 32'(DST_STRIDE));
      @(posedge MCLK);
      DST_TILED <= 1'b1;
      settle();
      chk("dst_stride", 32'h34, 32'(DST_STRIDE));
      @(posedge MCLK);
      DST_TILED <= 1'b0;
      $display("test strides done");
      for (int k = 0; k < 4; k++) begin
         i_host.src_fmt(4'h5, 2'h0, 2'(k), 14'h0, 1'b0);
         i_host.host_push(32'h11223344, v, d);
         chk("host_vld", 32'h1, 32'(v));
         chk("host_dout", sw[k], d);
      end
      $display("test swizzle done");
      conv(4'h0, 3'h5, 32'h00000080, 5'd0, COLOR_FG, 1'b0);
      conv(4'h0, 3'h5, 32'h00000080, 5'd1, COLOR_BG, 1'b0);
      conv(4'h0, 3'h1, 32'h00008000, 5'd8, COLOR_FG, 1'b0);
      conv(4'h1, 3'h1, 32'h000000a5, 5'd0, 32'h000000a5, 1'b0);
      conv(4'h1, 3'h3, 32'h000000a5, 5'd0, 32'h0, 1'b1);
      conv(4'h3, 3'h1, 32'h00008410, 5'd0, 32'h0, 1'b1);
      conv(4'h5, 3'h1, 32'h00123456, 5'd0, 32'h0, 1'b1);
      conv(4'h8, 3'h1, 32'h80b08040, 5'd0, 32'h0, 1'b1);
      conv(4'h3, 3'h3, 32'h0000f81f, 5'd0, 32'h0000f81f, 1'b0);
      conv(4'h3, 3'h4, 32'h00008410, 5'd0, 32'h00848284, 1'b0);
      conv(4'h3, 3'h5, 32'h00008410, 5'd0, 32'h00848284, 1'b0);
      conv(4'h4, 3'h3, 32'h00848284, 5'd0, 32'h00008410, 1'b0);
      conv(4'h4, 3'h5, 32'h00123456, 5'd0, 32'h00123456, 1'b0);
      conv(4'h5, 3'h3, 32'hff848284, 5'd0, 32'h00008410, 1'b0);
      conv(4'h5, 3'h4, 32'hff123456, 5'd0, 32'h00123456, 1'b0);
      conv(4'h5, 3'h5, 32'hff123456, 5'd0, 32'hff123456, 1'b0);
      conv(4'h8, 3'h5, 32'h80b08040, 5'd0, 32'h00404040, 1'b0);
      conv(4'h8, 3'h5, 32'h80b08040, 5'd1, 32'h00b0b0b0, 1'b0);
      conv(4'h9, 3'h4, 32'hb0804080, 5'd0, 32'h00404040, 1'b0);
      $display("test conversion done");
      close_out();
   end
endmodule // bsg_top_tb_top
